// File: logic/vpe_pkg.sv
package vpe_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [8:0] PARTNER_ABILITY_OFS = 9'h1d4; // byte offset, 32-bit path
  localparam logic [8:0] NEG_EXPANSION_OFS = 9'h1d8;
  localparam logic [4:0] PARTNER_ABILITY_IDX = 5'h05; // index, management path
  localparam logic [4:0] NEG_EXPANSION_IDX = 5'h06;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACK_BIT = 14;
  localparam int ASYM_BIT = 11;
  localparam int SYM_BIT = 10;
  localparam int ABIL_LSB = 5; // bits 8:5 speed/duplex abilities
  localparam int SEL_LSB = 0;
  localparam int PAGE_RX_BIT = 1;
  localparam int AN_ABLE_BIT = 0;

  // ----------------------------------------------------------------
  // fixed values
  // ----------------------------------------------------------------
  localparam logic [4:0] SELECTOR_8023 = 5'h01;
  localparam logic [3:0] ABIL_100_FD = 4'h8;
  localparam logic [3:0] ABIL_100_HD = 4'h4;
  localparam logic [3:0] ABIL_10_FD = 4'h2;
  localparam logic [3:0] ABIL_10_HD = 4'h1;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int AN_SETTLE_NS = 80; // page-received delay after a run
  localparam int AN_SETTLE_CYC =
    (AN_SETTLE_NS / CLK_PERIOD_NS < 1) ? 1 : AN_SETTLE_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic duplex_pol; // duplex polarity strap
    logic speed;      // speed strap, 1 = 100
    logic pause_res;  // flow-control result strap
  } vpe_strap_s;

  typedef struct packed {
    logic sym;
    logic asym;
  } vpe_pause_s;

  typedef enum logic [1:0] {
    VPE_ST_STRAP,
    VPE_ST_IDLE,
    VPE_ST_SETTLE
  } vpe_state_e;

endpackage : vpe_pkg

// File: logic/vpe_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for asynchronous pins
module vpe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------
  // stages
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta; // first stage, read only by the second

  // capture then re-time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : vpe_sync

`default_nettype wire

// File: logic/vpe_partner.sv
// Summary of operation
// RL1 - selector field always reads 00001
// RL2 - 32-bit words, 16 bits over management
// RL3 - no next page, fault, T4; instant word
// RL4 - partner pause follows local pause advert
// RL5 - partner pause frozen until next run
// RL6 - both advertised: strap picks sym/asym
// RL7 - fixed pause mapping table
// RL8 - bits 8:5 from duplex pin and straps
// RL9 - straps latched at reset release
// RL10 - negotiation-able clears when nothing common
// RL11 - parallel detection fault reads 0
// RL12 - both next-page-able bits read 0
// RL13 - page received latches, clears on read
// RL14 - advert bits 11/10 feed pause emulation
// RL15 - acknowledge bit always reads 1
// RL16 - all results updated together per run
`timescale 1ns/10ps
`default_nettype none

module vpe_partner (
  input wire logic mclk,
  input wire logic rst,
  // straps and pin, asynchronous to mclk
  input wire logic duplex_pol_strap,
  input wire logic speed_strap,
  input wire logic pause_result_strap,
  input wire logic port0_duplex_pin,
  // local advertisement fields from local_advert_reg
  input wire logic local_adv_asym,
  input wire logic local_adv_sym,
  input wire logic [3:0] local_adv_abil,
  // request a new negotiation run
  input wire logic an_restart,
  // 32-bit internal register read path
  input wire logic reg_rd_en,
  input wire logic [8:0] reg_addr,
  output logic [31:0] reg_rdata,
  output logic reg_rd_valid,
  // serial management read path, 16-bit view
  input wire logic mii_rd_en,
  input wire logic [4:0] mii_reg_idx,
  output logic [15:0] mii_rdata,
  output logic mii_rd_valid,
  // negotiation busy indicator
  output logic an_busy
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_sync; // duplex_pol, speed, pause_res, duplex pin

  vpe_sync #(
    .WIDTH(4)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({duplex_pol_strap, speed_strap, pause_result_strap, port0_duplex_pin}),
    .dout(pins_sync)
  );

  vpe_pkg::vpe_strap_s pin_straps; // live, synchronised strap levels
  logic duplex_pin; // live, synchronised duplex pin

  assign pin_straps = vpe_pkg::vpe_strap_s'(pins_sync[3:1]);
  assign duplex_pin = pins_sync[0];

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // partner pause from local advert and strap
  function automatic vpe_pkg::vpe_pause_s map_pause(
    input logic sym,
    input logic asym,
    input logic strap
  );
    vpe_pkg::vpe_pause_s r;
    r.sym = 1'b0;
    r.asym = 1'b0;
    if (sym && asym) begin
      // both advertised: strap chooses the emulated network
      r.sym = strap; // RL6
      r.asym = 1'b1; // RL7
    end else if (asym) begin
      r.sym = 1'b1; // RL7
      r.asym = 1'b1;
    end else if (sym) begin
      r.sym = 1'b1; // RL7
    end
    return r;
  endfunction : map_pause

  // partner speed/duplex abilities, bits 8:5
  function automatic logic [3:0] map_abil(
    input logic pin,
    input logic pol,
    input logic spd
  );
    logic [3:0] r;
    r = vpe_pkg::ABIL_10_HD;
    if (pin == pol) begin
      r = spd ? vpe_pkg::ABIL_100_FD : vpe_pkg::ABIL_10_FD; // RL8
    end else begin
      r = spd ? vpe_pkg::ABIL_100_HD : vpe_pkg::ABIL_10_HD; // RL8
    end
    return r;
  endfunction : map_abil

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  vpe_pkg::vpe_state_e state; // negotiation sequencer
  logic [1:0] strap_wait; // waits out the synchroniser after reset
  vpe_pkg::vpe_strap_s straps; // latched strap values
  vpe_pkg::vpe_pause_s lp_pause; // partner pause result
  logic [3:0] lp_abil; // partner ability bits 8:5
  logic lp_an_able; // partner negotiation-able
  logic page_rx; // latched page received
  logic [7:0] settle_cnt; // delay before page received sets
  logic page_set; // one-cycle set pulse at end of settle
  logic exp_read; // expansion register read this cycle

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------

  // straps reach the sync output two edges after release, so wait for them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_wait <= 2'h0;
    end else if (state == vpe_pkg::VPE_ST_STRAP) begin
      strap_wait <= strap_wait + 2'h1;
    end
  end

  // latch once at reset release; later pin changes are ignored
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      straps <= '0;
    end else if (state == vpe_pkg::VPE_ST_STRAP &&
                 strap_wait == 2'(vpe_pkg::SYNC_STAGES)) begin
      straps <= pin_straps; // RL9
    end
  end

  // ----------------------------------------------------------------
  // negotiation sequencer
  // ----------------------------------------------------------------

  // a run starts right after strap capture and on a restart request while idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= vpe_pkg::VPE_ST_STRAP;
    end else begin
      case (state)
        vpe_pkg::VPE_ST_STRAP: begin
          if (strap_wait == 2'(vpe_pkg::SYNC_STAGES)) begin
            state <= vpe_pkg::VPE_ST_SETTLE;
          end
        end
        vpe_pkg::VPE_ST_IDLE: begin
          if (an_restart) begin
            state <= vpe_pkg::VPE_ST_SETTLE;
          end
        end
        vpe_pkg::VPE_ST_SETTLE: begin
          if (page_set) begin
            state <= vpe_pkg::VPE_ST_IDLE;
          end
        end
        default: begin
          state <= vpe_pkg::VPE_ST_IDLE;
        end
      endcase
    end
  end

  // settle counter; restart during settle is absorbed by the running run
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      settle_cnt <= 8'h00;
    end else if (state == vpe_pkg::VPE_ST_SETTLE) begin
      settle_cnt <= settle_cnt + 8'h01;
    end else begin
      settle_cnt <= 8'h00;
    end
  end

  assign page_set = (state == vpe_pkg::VPE_ST_SETTLE) &&
                    (settle_cnt == 8'(vpe_pkg::AN_SETTLE_CYC - 1));
  assign an_busy = (state != vpe_pkg::VPE_ST_IDLE);

  // ----------------------------------------------------------------
  // negotiation results
  // ----------------------------------------------------------------

  // all three results load on the same edge so a read never mixes runs;
  // the partner word itself is treated as arriving instantly
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lp_pause <= '0;
      lp_abil <= 4'h0;
      lp_an_able <= 1'b0;
    end else if (page_set) begin // RL16 RL3
      lp_pause <= map_pause(local_adv_sym, local_adv_asym, straps.pause_res); // RL4 RL14 RL5
      lp_abil <= map_abil(duplex_pin, straps.duplex_pol, straps.speed); // RL8
      lp_an_able <= |(local_adv_abil &
                      map_abil(duplex_pin, straps.duplex_pol, straps.speed)); // RL10
    end
  end

  // ----------------------------------------------------------------
  // page received latch
  // ----------------------------------------------------------------
  assign exp_read = (reg_rd_en && reg_addr == vpe_pkg::NEG_EXPANSION_OFS) ||
                    (mii_rd_en && mii_reg_idx == vpe_pkg::NEG_EXPANSION_IDX);

  // set wins over a read in the same cycle, so a fresh page is never lost
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_rx <= 1'b0;
    end else if (page_set) begin
      page_rx <= 1'b1; // RL13
    end else if (exp_read) begin
      page_rx <= 1'b0; // RL13
    end
  end

  // ----------------------------------------------------------------
  // register images
  // ----------------------------------------------------------------
  logic [15:0] ability_word; // partner ability, low half
  logic [15:0] expansion_word; // expansion, low half

  always_comb begin
    ability_word = 16'h0000; // next page, fault, T4 stay 0 // RL3
    ability_word[vpe_pkg::ACK_BIT] = 1'b1; // RL15
    ability_word[vpe_pkg::ASYM_BIT] = lp_pause.asym;
    ability_word[vpe_pkg::SYM_BIT] = lp_pause.sym;
    ability_word[vpe_pkg::ABIL_LSB +: 4] = lp_abil;
    ability_word[vpe_pkg::SEL_LSB +: 5] = vpe_pkg::SELECTOR_8023; // RL1
  end

  // fault and both next-page bits held at 0
  always_comb begin
    expansion_word = 16'h0000; // RL11 RL12
    expansion_word[vpe_pkg::PAGE_RX_BIT] = page_rx;
    expansion_word[vpe_pkg::AN_ABLE_BIT] = lp_an_able;
  end

  // ----------------------------------------------------------------
  // 32-bit read path
  // ----------------------------------------------------------------

  // upper half is padding and reads 0; unmapped offsets read 0
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= vpe_pkg::ZERO_WORD;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (!reg_rd_en) begin
        reg_rdata <= reg_rdata;
      end else if (reg_addr == vpe_pkg::PARTNER_ABILITY_OFS) begin
        reg_rdata <= {16'h0000, ability_word}; // RL2
      end else if (reg_addr == vpe_pkg::NEG_EXPANSION_OFS) begin
        reg_rdata <= {16'h0000, expansion_word}; // RL2
      end else begin
        reg_rdata <= vpe_pkg::ZERO_WORD;
      end
    end
  end

  // ----------------------------------------------------------------
  // management read path
  // ----------------------------------------------------------------

  // only the low 16 bits exist over the serial protocol
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mii_rdata <= 16'h0000;
      mii_rd_valid <= 1'b0;
    end else begin
      mii_rd_valid <= mii_rd_en;
      if (!mii_rd_en) begin
        mii_rdata <= mii_rdata;
      end else if (mii_reg_idx == vpe_pkg::PARTNER_ABILITY_IDX) begin
        mii_rdata <= ability_word; // RL2
      end else if (mii_reg_idx == vpe_pkg::NEG_EXPANSION_IDX) begin
        mii_rdata <= expansion_word; // RL2
      end else begin
        mii_rdata <= 16'h0000;
      end
    end
  end

endmodule : vpe_partner

`default_nettype wire

// File: testbench/vpe_partner_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module vpe_partner_asserts (
  input wire logic mclk,
  input wire logic rst,
  input wire logic duplex_pol_strap,
  input wire logic speed_strap,
  input wire logic pause_result_strap,
  input wire logic port0_duplex_pin,
  input wire logic local_adv_asym,
  input wire logic local_adv_sym,
  input wire logic [3:0] local_adv_abil,
  input wire logic an_restart,
  input wire logic reg_rd_en,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic mii_rd_en,
  input wire logic [4:0] mii_reg_idx,
  input wire logic [15:0] mii_rdata,
  input wire logic mii_rd_valid,
  input wire logic an_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // sequences
  // ------------------------------------------------------------
  sequence exp_rd_s;
    reg_rd_en && reg_addr == vpe_pkg::NEG_EXPANSION_OFS;
  endsequence
  sequence run_taken_s;
    an_restart && !an_busy;
  endsequence
  // ten busy cycles, then idle with results loaded
  sequence settle_s;
    an_busy [*8] ##1 an_busy ##1 an_busy ##1 !an_busy;
  endsequence
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  read_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("word read not answered");
  mgmt_answer_a: assert property (mii_rd_en |=> mii_rd_valid)
    else $error("management read not answered");
  no_spurious_a: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("valid without request");
  upper_pad_a: assert property (reg_rd_valid |-> reg_rdata[31:16] == 16'h0)
    else $error("padding bits not zero");
  ability_fixed_a: assert property (reg_rd_valid &&
    $past(reg_addr) == vpe_pkg::PARTNER_ABILITY_OFS |-> reg_rdata[4:0] == 5'h01 &&
    reg_rdata[15:12] == 4'h4 && !reg_rdata[9])
    else $error("ability fixed bits wrong");
  mgmt_ability_a: assert property (mii_rd_valid &&
    $past(mii_reg_idx) == vpe_pkg::PARTNER_ABILITY_IDX |->
    mii_rdata[14] && mii_rdata[4:0] == 5'h01)
    else $error("management ability fixed bits wrong");
  exp_zero_a: assert property (reg_rd_valid &&
    $past(reg_addr) == vpe_pkg::NEG_EXPANSION_OFS |-> reg_rdata[15:2] == 14'h0)
    else $error("expansion constant bits wrong");
  settle_time_a: assert property (run_taken_s |=> settle_s)
    else $error("run did not settle in ten cycles");
  page_clear_a: assert property ((!an_busy) throughout (exp_rd_s ##3 exp_rd_s)
    |=> !reg_rdata[1])
    else $error("page received not cleared by read");
endmodule : vpe_partner_asserts

`default_nettype wire

// File: testbench/vpe_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// management host: one read at a time on either path
module vpe_host_model (
  input wire logic mclk,
  output logic reg_rd_en,
  output logic [8:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rd_valid,
  output logic mii_rd_en,
  output logic [4:0] mii_reg_idx,
  input wire logic [15:0] mii_rdata,
  input wire logic mii_rd_valid
);
  initial begin
    reg_rd_en = 1'b0;
    mii_rd_en = 1'b0;
    reg_addr = 9'h000;
    mii_reg_idx = 5'h00;
  end
  // ------------------------------------------------------------
  // read task
  // ------------------------------------------------------------
  // idle address lines show the inverse so stale values never match
  task automatic rd(input logic mii, input logic [8:0] a, output logic [31:0] d,
                    output logic ok);
    @(posedge mclk);
    if (mii) begin
      mii_rd_en <= 1'b1;
      mii_reg_idx <= (a == 9'h1d4) ? 5'h05 : (a == 9'h1d8) ? 5'h06 : a[4:0];
    end else begin
      reg_rd_en <= 1'b1;
      reg_addr <= a;
    end
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    mii_rd_en <= 1'b0;
    reg_addr <= ~a;
    mii_reg_idx <= ~a[4:0];
    @(posedge mclk);
    ok = mii ? mii_rd_valid : reg_rd_valid;
    d = mii ? {16'h0, mii_rdata} : reg_rdata;
  endtask : rd
endmodule : vpe_host_model

`default_nettype wire

// File: testbench/vpe_partner_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("FAIL %0t: got %h exp %h", $time, (g), (e)); end end

module vpe_partner_tb_top;
  logic mclk, rst, pol, spd, fc, pin, asym, sym, an_restart, an_busy, ok;
  logic reg_rd_en, reg_rd_valid, mii_rd_en, mii_rd_valid, l_pol, l_spd, l_fc, able;
  logic [3:0] abil;
  logic [8:0] reg_addr;
  logic [4:0] mii_reg_idx;
  logic [31:0] reg_rdata, d, e;
  logic [15:0] mii_rdata;
  int failures = 0;
  int tests_run = 0;
  int seed = 38418;

  vpe_partner dut_u (.mclk(mclk), .rst(rst), .duplex_pol_strap(pol), .speed_strap(spd),
    .pause_result_strap(fc), .port0_duplex_pin(pin), .local_adv_asym(asym),
    .local_adv_sym(sym), .local_adv_abil(abil), .an_restart(an_restart),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .mii_rd_en(mii_rd_en), .mii_reg_idx(mii_reg_idx),
    .mii_rdata(mii_rdata), .mii_rd_valid(mii_rd_valid), .an_busy(an_busy));
  vpe_host_model host_u (.mclk(mclk), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .mii_rd_en(mii_rd_en),
    .mii_reg_idx(mii_reg_idx), .mii_rdata(mii_rdata), .mii_rd_valid(mii_rd_valid));

  // ------------------------------------------------------------
  // clock, watchdog, verdict
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // whole run is well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    test_done;
  end
  task automatic test_done;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [3:0] abil_of(input logic pn, input logic pl, input logic sp);
    return (pn == pl) ? (sp ? 4'h8 : 4'h2) : (sp ? 4'h4 : 4'h1);
  endfunction : abil_of
  function automatic logic [31:0] exp_word(input logic s, input logic a, input logic st,
                                           input logic [3:0] ab);
    logic ps;
    ps = (s ^ a) | (s & a & st);
    return {16'h0, 4'h4, a, ps, 1'b0, ab, 5'h01};
  endfunction : exp_word

  // ------------------------------------------------------------
  // negotiation helpers
  // ------------------------------------------------------------
  task automatic wait_idle;
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      if (an_busy === 1'b0) break;
    end
    `CHK(an_busy, 1'b0)
  endtask : wait_idle
  task automatic run;
    an_restart <= 1'b1;
    @(posedge mclk);
    an_restart <= 1'b0;
    wait_idle;
  endtask : run

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {rst, an_restart, pin, asym, sym, pol, spd, fc} = 8'h80;
    abil = 4'h0;
    for (int st = 0; st < 2; st++) begin
      rst <= 1'b1;
      pol <= 1'($random(seed));
      spd <= 1'($random(seed));
      fc <= st[0];
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      wait_idle;
      // flip straps after capture: results must keep the latched ones
      {l_pol, l_spd, l_fc} = {pol, spd, fc};
      pol <= ~pol;
      spd <= ~spd;
      fc <= ~fc;
      for (int p = 0; p < 8; p++) begin
        sym <= p[0];
        asym <= p[1];
        abil <= (p == 5) ? 4'h0 : 4'($random(seed));
        pin <= 1'($random(seed));
        run;
        e = exp_word(sym, asym, l_fc, abil_of(pin, l_pol, l_spd));
        able = |(abil & abil_of(pin, l_pol, l_spd));
        host_u.rd(1'b0, 9'h1d4, d, ok);
        `CHK({ok, d}, {1'b1, e})
        host_u.rd(1'b1, 9'h1d4, d, ok);
        `CHK({ok, d}, {1'b1, 16'h0, e[15:0]})
        // advert and pin change after the run must not leak through
        sym <= ~sym;
        asym <= ~asym;
        pin <= ~pin;
        host_u.rd(1'b0, 9'h1d8, d, ok);
        `CHK(d, {30'h0, 1'b1, able})
        host_u.rd(1'b0, 9'h1d8, d, ok);
        `CHK(d, {30'h0, 1'b0, able})
        host_u.rd(1'b1, 9'h1d4, d, ok);
        `CHK(d, {16'h0, e[15:0]})
      end
      host_u.rd(1'b0, 9'h1dc, d, ok);
      `CHK(d, 32'h0)
    end
    test_done;
  end
endmodule : vpe_partner_tb_top

bind vpe_partner vpe_partner_asserts chk_u (.mclk(mclk), .rst(rst),
  .duplex_pol_strap(duplex_pol_strap), .speed_strap(speed_strap),
  .pause_result_strap(pause_result_strap), .port0_duplex_pin(port0_duplex_pin),
  .local_adv_asym(local_adv_asym), .local_adv_sym(local_adv_sym),
  .local_adv_abil(local_adv_abil), .an_restart(an_restart), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
  .mii_rd_en(mii_rd_en), .mii_reg_idx(mii_reg_idx), .mii_rdata(mii_rdata),
  .mii_rd_valid(mii_rd_valid), .an_busy(an_busy));

`default_nettype wire
